// [pso_params.svh]
// constants and contract list for the pipelined sample output port
// Contract
// - a new sample of the analog input is taken on every falling edge of the converter clock.
// - while standby is high the converter stays powered down and every data output floats.
// - data outputs are driven only when output enable (active low) and standby are both low.
// - if output enable (active low) or standby is high, all data outputs float.
// - each result is a 10-bit parallel word, bit 0 least significant and bit 9 most significant.
// - a result becomes valid 2.0 clock cycles after its sampling edge plus the clock-to-output delay.
// - results are unsigned straight binary, lowest input to zero and highest to all ones.
// - input above the top reference yields 3FFh and input below the bottom reference yields 000h.
`ifndef PSO_PARAMS_SVH
`define PSO_PARAMS_SVH
`define PSO_CODE_WIDTH     10
`define PSO_CODE_MAX       10'h3FF
`define PSO_CODE_MIN       10'h000
`define PSO_LATENCY        2
`define PSO_FIFO_DEPTH     4
`define PSO_INPUT_WIDTH    12
`define PSO_MAX_RATE_MSPS  30
`define PSO_CLOCK_MHZ      200
`define PSO_MIN_CLK_CYCLES ((`PSO_CLOCK_MHZ + `PSO_MAX_RATE_MSPS - 1) / `PSO_MAX_RATE_MSPS)
`define PSO_WAKE_NS        700
`define PSO_CLOCK_NS       5
`define PSO_WAKE_CYCLES    ((`PSO_WAKE_NS + `PSO_CLOCK_NS - 1) / `PSO_CLOCK_NS)
`endif

// [pso_pkg.sv]
// types shared by the sample output port
`default_nettype none
package pso_pkg;
  typedef logic [9:0] pso_code_t;
  typedef enum logic [1:0] {
    PSO_ST_STANDBY,
    PSO_ST_RUN
  } pso_state_t;
endpackage
`default_nettype wire

// [pso_fifo.sv]
// small flip-flop fifo with valid/ready on both sides
`default_nettype none
module pso_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_flush,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (i_flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [pso_quantizer.sv]
// clamps and maps the sampled input level to a straight binary code
`default_nettype none
`include "pso_params.svh"
module pso_quantizer #(
  parameter int IN_WIDTH = `PSO_INPUT_WIDTH
) (
  input  wire logic [IN_WIDTH-1:0] i_level,
  input  wire logic [IN_WIDTH-1:0] i_ref_low,
  input  wire logic [IN_WIDTH-1:0] i_ref_high,
  output pso_pkg::pso_code_t       o_code
);
  import pso_pkg::*;
  // level is unsigned, ref_low..ref_high is the conversion span
  wire              below = (i_level <= i_ref_low);
  wire              above = (i_level >= i_ref_high);
  wire [IN_WIDTH-1:0] span = i_ref_high - i_ref_low;
  wire [IN_WIDTH-1:0] offs = i_level - i_ref_low;
  wire [IN_WIDTH+9:0] prod = {10'h000, offs} * (IN_WIDTH+10)'(`PSO_CODE_MAX);
  // span is nonzero whenever neither clamp applies
  wire [IN_WIDTH+9:0] quot = (span == '0) ? '0 : prod / {10'h000, span};

  assign o_code = above ? `PSO_CODE_MAX :
                  below ? `PSO_CODE_MIN :
                  quot[9:0];
endmodule
`default_nettype wire

// [pso_top.sv]
// sample output port: falling-edge capture, two-cycle pipeline, three-state data bus
`default_nettype none
`include "pso_params.svh"
module pso_top #(
  parameter int IN_WIDTH   = `PSO_INPUT_WIDTH,
  parameter int FIFO_DEPTH = `PSO_FIFO_DEPTH,
  parameter int WAKE_CYCLES = `PSO_WAKE_CYCLES
) (
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  input  wire logic                i_sample_clock,
  input  wire logic [IN_WIDTH-1:0] i_analog_input,
  input  wire logic [IN_WIDTH-1:0] i_ref_low,
  input  wire logic [IN_WIDTH-1:0] i_ref_high,
  input  wire logic                i_standby_request,
  input  wire logic                i_output_enable_n,
  output pso_pkg::pso_code_t       o_sample_code_bits,
  output logic [9:0]               o_sample_code_bits_oe,
  output logic                     o_powered_down,
  output logic                     o_wake_done,
  output logic                     o_overflow
);
  import pso_pkg::*;

  // two-flop synchronisers for pins from outside the clock domain
  logic [2:0] clk_sync;
  logic [1:0] stby_sync;
  logic [1:0] oe_n_sync;
  logic [IN_WIDTH-1:0] level_s1;
  logic [IN_WIDTH-1:0] level_s2;
  logic [IN_WIDTH-1:0] ref_low_s1;
  logic [IN_WIDTH-1:0] ref_low_s2;
  logic [IN_WIDTH-1:0] ref_high_s1;
  logic [IN_WIDTH-1:0] ref_high_s2;

  // the level bus has no handshake: it must hold still around each falling
  // pin edge, or a word caught mid-change reaches the quantiser
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_sync  <= 3'h0;
      stby_sync <= 2'h3;
      oe_n_sync <= 2'h3;
      level_s1  <= '0;
      level_s2  <= '0;
      ref_low_s1  <= '0;
      ref_low_s2  <= '0;
      ref_high_s1 <= '0;
      ref_high_s2 <= '0;
    end else begin
      clk_sync  <= {clk_sync[1:0], i_sample_clock};
      stby_sync <= {stby_sync[0], i_standby_request};
      oe_n_sync <= {oe_n_sync[0], i_output_enable_n};
      level_s1  <= i_analog_input;
      level_s2  <= level_s1;
      ref_low_s1  <= i_ref_low;
      ref_low_s2  <= ref_low_s1;
      ref_high_s1 <= i_ref_high;
      ref_high_s2 <= ref_high_s1;
    end
  end

  wire standby  = stby_sync[1];
  wire oe_n     = oe_n_sync[1];
  // edge detect reads only the second and third stages
  wire fall     = clk_sync[2] && !clk_sync[1];
  wire drive_on = !oe_n && !standby;

  pso_code_t quant_code;

  pso_quantizer #(
    .IN_WIDTH (IN_WIDTH)
  ) pso_quantizer_inst (
    .i_level    (level_s2),
    .i_ref_low  (ref_low_s2),
    .i_ref_high (ref_high_s2),
    .o_code     (quant_code)
  );

  // state: standby holds the converter off and empties the pipeline
  pso_state_t state;
  pso_state_t next_state;
  localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);
  logic [WAKE_W-1:0] wake_cnt;

  always_comb begin
    next_state = state;
    case (state)
      PSO_ST_STANDBY: begin
        if (!standby) next_state = PSO_ST_RUN;
      end
      PSO_ST_RUN: begin
        if (standby) next_state = PSO_ST_STANDBY;
      end
      default: next_state = PSO_ST_STANDBY;
    endcase
  end

  wire running = (state == PSO_ST_RUN) && !standby;

  // pipeline: stage 0 taken at sampling fall, result released LATENCY falls later
  pso_code_t pipe [`PSO_LATENCY];
  logic [`PSO_LATENCY-1:0] pipe_vld;
  wire sample_now = fall && running;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= PSO_ST_STANDBY;
      wake_cnt <= '0;
      pipe_vld <= '0;
      for (int k = 0; k < `PSO_LATENCY; k++) pipe[k] <= '0;
    end else begin
      state <= next_state;
      if (!running) begin
        wake_cnt <= '0;
        pipe_vld <= '0;
      end else if (wake_cnt != WAKE_W'(WAKE_CYCLES)) begin
        wake_cnt <= wake_cnt + 1'b1;
      end
      if (sample_now) begin
        pipe[0]  <= quant_code;
        pipe_vld <= {pipe_vld[`PSO_LATENCY-2:0], 1'b1};
        for (int k = 1; k < `PSO_LATENCY; k++) pipe[k] <= pipe[k-1];
      end
    end
  end

  // result enters fifo on the fall two cycles after its sample
  wire       push_valid = sample_now && pipe_vld[`PSO_LATENCY-1];
  wire       push_ready;
  wire       pop_valid;
  pso_code_t pop_data;

  // fifo decouples the pipeline from the output register; the bus drains
  // one word per clock while running, so a full fifo means words are being dropped
  pso_fifo #(
    .WIDTH (`PSO_CODE_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) pso_fifo_inst (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_flush     (!running),
    .i_in_valid  (push_valid),
    .o_in_ready  (push_ready),
    .i_in_data   (pipe[`PSO_LATENCY-1]),
    .o_out_valid (pop_valid),
    .i_out_ready (running),
    .o_out_data  (pop_data)
  );

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_sample_code_bits    <= `PSO_CODE_MIN;
      o_sample_code_bits_oe <= 10'h000;
      o_powered_down        <= 1'b1;
      o_wake_done           <= 1'b0;
      o_overflow            <= 1'b0;
    end else begin
      if (pop_valid && running) o_sample_code_bits <= pop_data;
      o_sample_code_bits_oe <= {10{drive_on}};
      o_powered_down        <= !running;
      o_wake_done           <= running && (wake_cnt == WAKE_W'(WAKE_CYCLES));
      o_overflow            <= push_valid && !push_ready;
    end
  end
endmodule
`default_nettype wire

// [pso_top_checker.sv]
// assertions on the sample output port pins
`default_nettype none
`include "pso_params.svh"
module pso_top_checker #(
  parameter int WAKE_CYCLES = `PSO_WAKE_CYCLES
) (
  input wire logic               i_clock,
  input wire logic               i_nrst,
  input wire logic               i_sample_clock,
  input wire logic               i_standby_request,
  input wire logic               i_output_enable_n,
  input wire pso_pkg::pso_code_t o_sample_code_bits,
  input wire logic [9:0]         o_sample_code_bits_oe,
  input wire logic               o_powered_down,
  input wire logic               o_wake_done,
  input wire logic               o_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  import pso_pkg::*;
  localparam int WAKE_MAX = WAKE_CYCLES + 4;
  logic       prev;
  logic [3:0] since;
  // saturates so a stopped converter clock cannot wrap
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      prev  <= 1'b0;
      since <= 4'hF;
    end else begin
      prev  <= i_sample_clock;
      since <= (prev && !i_sample_clock) ? 4'h0 : since + 4'(since != 4'hF);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_on; (!i_standby_request && !i_output_enable_n) [*5]; endsequence
  sequence s_down; i_standby_request [*5]; endsequence
  a_oe_on: assert property (s_on |-> o_sample_code_bits_oe == 10'h3FF)
    else $error("bus not driven");
  a_oe_standby: assert property (s_down |-> o_sample_code_bits_oe == 10'h000)
    else $error("bus driven in standby");
  a_oe_off: assert property (i_output_enable_n [*5] |-> o_sample_code_bits_oe == 10'h000)
    else $error("bus driven while disabled");
  a_oe_cause: assert property (o_sample_code_bits_oe != 10'h000 |-> !$past(i_output_enable_n, 3) && !$past(i_standby_request, 3))
    else $error("bus driven without cause");
  a_down_held: assert property (s_down |-> o_powered_down)
    else $error("not powered down");
  a_down_left: assert property ((!i_standby_request) [*6] |-> !o_powered_down)
    else $error("still powered down");
  a_code_fall: assert property ($changed(o_sample_code_bits) && !o_powered_down |-> since inside {[1:10]})
    else $error("word changed without sample edge");
  a_wake_time: assert property ($fell(o_powered_down) |-> !o_wake_done ##[1:WAKE_MAX] o_wake_done)
    else $error("wake flag late");
  a_no_overflow: assert property (!o_overflow)
    else $error("output word dropped");
endmodule
`default_nettype wire

// [pso_host_model.sv]
// host model: drives the converter clock pin
`default_nettype none
module pso_host_model (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  output var logic  o_sample_clock
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] count;
  // 32-cycle period keeps the pin far below the rate ceiling
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      count          <= 4'h0;
      o_sample_clock <= 1'b1;
    end else begin
      count <= count + 4'h1;
      if (&count) o_sample_clock <= !o_sample_clock;
    end
  end
endmodule
`default_nettype wire

// [tb_pso_top.sv]
// self-checking bench for the sample output port
`default_nettype none
module tb_pso_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pso_pkg::*;
  logic        i_clock = 1'b0;
  logic        i_nrst = 1'b0;
  logic        sclk;
  logic [11:0] level = 12'h000;
  logic        standby = 1'b0;
  logic        oe_n = 1'b0;
  pso_code_t   code;
  logic [9:0]  oe;
  logic        down;
  logic        wake;
  logic        ovf;
  logic        ovf_seen = 1'b0;
  int          err_total = 0;
  int          num_checks = 0;
  logic [11:0] lv [8] = '{12'h050, 12'h233, 12'h4FF, 12'h600, 12'h100, 12'h101, 12'h2AA, 12'h4FE};
  always #2.5 i_clock = !i_clock;
  pso_host_model pso_host_model_inst (.i_clock(i_clock), .i_nrst(i_nrst), .o_sample_clock(sclk));
  // a span of 3FF steps makes each code the level minus the low limit
  pso_top #(.WAKE_CYCLES(4)) pso_top_inst (.i_clock(i_clock), .i_nrst(i_nrst), .i_sample_clock(sclk),
    .i_analog_input(level), .i_ref_low(12'h100), .i_ref_high(12'h4FF), .i_standby_request(standby),
    .i_output_enable_n(oe_n), .o_sample_code_bits(code), .o_sample_code_bits_oe(oe),
    .o_powered_down(down), .o_wake_done(wake), .o_overflow(ovf));
  // the overflow pulse lasts one cycle, so it is caught in a sticky flag
  always @(posedge i_clock) if (ovf === 1'b1) ovf_seen <= 1'b1;
  task automatic tick();
    @(posedge i_clock);
    #1;
  endtask
  task automatic chk_word(input logic [9:0] got, input logic [9:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: word %h not %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: flag %b not %b", $time, got, exp);
    end
  endtask
  function automatic logic [9:0] exp_code(input logic [11:0] v);
    if (v >= 12'h4FF) return 10'h3FF;
    if (v <= 12'h100) return 10'h000;
    return 10'(v - 12'h100);
  endfunction
  task automatic wait_wake();
    for (int n = 0; n < 60 && wake !== 1'b1; n++) tick();
    chk_flag(wake, 1'b1);
  endtask
  // the level is set a half period ahead so it is settled when the pin falls
  task automatic run_codes(input int rot);
    for (int i = 0; i < 10; i++) begin
      while (sclk !== 1'b0) tick();
      while (sclk !== 1'b1) tick();
      level = lv[(i + rot) % 8];
      while (sclk !== 1'b0) tick();
      repeat (12) tick();
      if (i >= 2) chk_word(code, exp_code(lv[(i - 2 + rot) % 8]));
    end
    chk_flag(ovf_seen, 1'b0);
  endtask
  task automatic t_float();
    oe_n = 1'b1;
    repeat (6) tick();
    chk_word(oe, 10'h000);
    oe_n = 1'b0;
    repeat (6) tick();
    chk_word(oe, 10'h3FF);
    $display("test float done");
  endtask
  task automatic t_standby();
    standby = 1'b1;
    repeat (8) tick();
    chk_flag(down, 1'b1);
    chk_word(oe, 10'h000);
    standby = 1'b0;
    wait_wake();
    run_codes(3);
    $display("test standby done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    #1;
    i_nrst = 1'b1;
    wait_wake();
    run_codes(0);
    $display("test codes done");
    t_float();
    t_standby();
    stop_test();
  end
  initial begin
    #20000;
    err_total++;
    stop_test();
  end
endmodule
bind pso_top pso_top_checker #(.WAKE_CYCLES(WAKE_CYCLES)) pso_top_checker_inst (.i_clock(i_clock),
  .i_nrst(i_nrst), .i_sample_clock(i_sample_clock), .i_standby_request(i_standby_request),
  .i_output_enable_n(i_output_enable_n), .o_sample_code_bits(o_sample_code_bits),
  .o_sample_code_bits_oe(o_sample_code_bits_oe), .o_powered_down(o_powered_down), .o_wake_done(o_wake_done),
  .o_overflow(o_overflow));
`default_nettype wire
